// ---- rtl/lsm_link_monitor.sv ----
// Link status, error reporting and initialization control for a multi-lane serial link.
// Notes on behaviour
// R1: Recoverable error pulses each cycle errors seen.
// R2: Watch transceivers for faults, raise fatal error.
// R3: Bad-header bursts realign lane, never fatal.
// R4: Fatal error resets device, then reinitializes.
// R5: Transmit buffer overflow or underflow is fatal.
// R6: Receive bonding FIFO over/underflow is fatal.
// R7: Invalid 2-bit sync header is recoverable error.
// R8: Unknown control block kind is recoverable error.
// R9: Initialization starts itself and repeats until usable.
// R10: Per-lane ready bit after lane stage.
// R11: Channel ready only after full initialization.
// R12: Received data qualified only by stream valid.
// R13: No transmit before channel ready.
// R14: No received data until all lanes ready.
// R15: Simplex uses timers to judge partner ready.
// R16: Simplex transmitter sends periodic bonding blocks.
// R17: Simplex link recovers at next bonding block.
// R18: Broken simplex link waits for remote bond.
// R19: Receive side ready before transmit side.
// R20: Simplex transmit lanes ready after 24-bit timer.
// R21: Integrator sizes partner timer for reset order.
// R22: Reset clears both transmit and receive halves.
// R23: Outputs synchronous and cleared during reset.
`timescale 1ns/100ps
module lsm_link_monitor
#(
	parameter logic [23:0] BOND_PERIOD = 24'h002710
)
(
	// Clock and reset.
	input  wire logic                                      clk,
	input  wire logic                                      sys_rst,
	// Register bus.
	input  wire lsm_pkg::lsm_apb_req_type                  apbReq,
	output lsm_pkg::lsm_apb_rsp_type                       apbRsp,
	// Transceiver lanes.
	input  wire lsm_pkg::lsm_lane_in_type [lsm_pkg::NUM_LANES-1:0] laneIn,
	// Receive stream qualifier.
	input  wire logic                                      rxValidIn,
	output logic                                           rxStreamValid,
	// Errors.
	output logic                                           softErr,
	output logic                                           hardErr,
	output logic                                           txHardErr,
	output logic                                           rxHardErr,
	// Readiness.
	output logic [lsm_pkg::NUM_LANES-1:0]                  laneUp,
	output logic                                           channelUp,
	output logic                                           txReady,
	output logic                                           sendBond
);
	import lsm_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Signals.

	lsm_init_state_type     initState;
	lsm_init_state_type     next_initState;
	logic [NUM_LANES-1:0]   locked;
	logic [NUM_LANES-1:0]   slip;
	logic [NUM_LANES-1:0]   badHdr;
	logic [NUM_LANES-1:0]   badKind;
	logic [NUM_LANES-1:0]   bondNow;
	logic [NUM_LANES-1:0]   bondSeen;
	logic                   allLocked;
	logic                   softDet;
	logic                   txFault;
	logic                   rxFault;
	logic                   lockFault;
	logic                   fatalDet;
	logic                   realign;
	logic [4:0]             holdCnt;
	logic                   laneUpTx;
	logic                   linkTimerLoad;
	logic                   linkTimerDone;
	logic                   bondTimerLoad;
	logic                   bondTimerDone;
	logic                   simplexMode;
	logic                   simplexTx;
	logic                   restartReq;
	logic [TIMER_W-1:0]     timerValue;
	logic [31:0]            softCount;
	logic                   apbAccess;
	logic                   apbWrite;
	logic [31:0]            next_prdata;
	logic                   next_pslverr;

	////////////////////////////////////////////////////////////////////////////////
	// Lane alignment and per-lane decode.

	// R3: per-lane alignment
	genvar g;
	generate
		for (g = 0; g < NUM_LANES; g++)
		begin : gLane
			lsm_lane_align uAlign
			(
				.clk      (clk),
				.sys_rst  (sys_rst),
				.restart  (initState == ST_RESET),
				.hdrValid (laneIn[g].hdrValid),
				.header   (laneIn[g].header),
				.locked   (locked[g]),
				.slip     (slip[g])
			);

			// R7: bad sync header
			assign badHdr[g] = laneIn[g].hdrValid && (laneIn[g].header != HDR_DATA) &&
				(laneIn[g].header != HDR_CTRL);
			// R8: unknown block kind
			assign badKind[g] = laneIn[g].hdrValid && (laneIn[g].header == HDR_CTRL) &&
				!kind_known(laneIn[g].kind);
			assign bondNow[g] = laneIn[g].hdrValid && (laneIn[g].header == HDR_CTRL) &&
				(laneIn[g].kind == KIND_BOND);
		end
	endgenerate

	assign allLocked = &locked;
	assign realign   = |slip;

	// Fault summary over all lanes; simplex sides ignore the half they lack.
	always_comb
	begin
		txFault   = 1'b0;
		rxFault   = 1'b0;
		lockFault = 1'b0;
		for (int i = 0; i < NUM_LANES; i++)
		begin
			txFault   = txFault || (laneIn[i].txBufErr && !(simplexMode && !simplexTx));
			rxFault   = rxFault || (laneIn[i].rxBufErr && !(simplexMode && simplexTx));
			lockFault = lockFault || !laneIn[i].pllLock;
		end
	end

	assign softDet  = |(badHdr | badKind);
	assign fatalDet = (txFault || rxFault || lockFault) && (initState != ST_RESET);

	////////////////////////////////////////////////////////////////////////////////
	// Error outputs.

	// R1: recoverable error pulse
	always_ff @(posedge clk)
	begin
		softErr <= !sys_rst && softDet;
	end

	// R2: fatal error outputs
	// R5: transmit side fault
	// R6: receive side fault
	always_ff @(posedge clk)
	begin
		hardErr   <= !sys_rst && fatalDet;
		txHardErr <= !sys_rst && fatalDet && txFault;
		rxHardErr <= !sys_rst && fatalDet && rxFault;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Timers for simplex operation.

	// R15: partner timer
	lsm_timer uLinkTimer
	(
		.clk       (clk),
		.sys_rst   (sys_rst),
		.load      (linkTimerLoad),
		.loadValue (timerValue),
		.done      (linkTimerDone)
	);

	// R16: bond period timer
	lsm_timer uBondTimer
	(
		.clk       (clk),
		.sys_rst   (sys_rst),
		.load      (bondTimerLoad),
		.loadValue (BOND_PERIOD),
		.done      (bondTimerDone)
	);

	// Bond timer reloads in the reset state and restarts after each expiry, in every mode.
	assign bondTimerLoad = (initState == ST_RESET) || bondTimerDone;

	////////////////////////////////////////////////////////////////////////////////
	// Initialization state machine.

	// R9: self-starting initialization
	always_comb
	begin
		next_initState = initState;
		case (initState)
			ST_RESET:
				if (holdCnt == RESET_HOLD - 5'h1)
					next_initState = ST_LANE;
			ST_LANE:
				if (simplexMode && simplexTx ? linkTimerDone && !linkTimerLoad : allLocked)
					next_initState = ST_BOND;
			ST_BOND:
				if (simplexMode && simplexTx)
				begin
					if (linkTimerDone && !linkTimerLoad) // Skip the expiry of the lane stage.
						next_initState = ST_READY;
				end
				else if (!allLocked)
					next_initState = ST_LANE;
				else if (&(bondSeen | bondNow))
					next_initState = ST_READY;
			ST_READY:
				// R18: leave ready on break
				if (!(simplexMode && simplexTx) && !allLocked)
					next_initState = simplexMode ? ST_WAIT_REMOTE : ST_LANE;
			ST_WAIT_REMOTE:
				// R17: recover on bond block
				if (allLocked && |bondNow)
					next_initState = ST_READY;
			default:
				next_initState = ST_RESET;
		endcase
		// R4: self reset on fatal error
		if (fatalDet || restartReq)
			next_initState = ST_RESET;
	end

	// R22: reset clears both halves
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			initState <= ST_RESET;
		else
			initState <= next_initState;
	end

	// Hold count spent in the reset state before lanes are watched.
	always_ff @(posedge clk)
	begin
		if (sys_rst || initState != ST_RESET)
			holdCnt <= '0;
		else
			holdCnt <= holdCnt + 1'b1;
	end

	// R20 R19: timer reloads on stage entry
	always_ff @(posedge clk)
	begin
		linkTimerLoad <= !sys_rst && (next_initState != initState) &&
			(next_initState == ST_LANE || next_initState == ST_BOND);
	end

	// Bond blocks collected per lane during the bonding stage.
	always_ff @(posedge clk)
	begin
		if (sys_rst || initState != ST_BOND)
			bondSeen <= '0;
		else
			bondSeen <= bondSeen | bondNow;
	end

	// R20: simplex transmit lanes ready on timer expiry
	always_ff @(posedge clk)
	begin
		if (sys_rst || initState == ST_RESET)
			laneUpTx <= 1'b0;
		else if (initState == ST_LANE && linkTimerDone && !linkTimerLoad)
			laneUpTx <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Readiness and data gating outputs.

	// R10: per-lane ready vector
	// R23: cleared in reset
	always_ff @(posedge clk)
	begin
		for (int i = 0; i < NUM_LANES; i++)
			laneUp[i] <= !sys_rst && initState != ST_RESET &&
				(simplexMode && simplexTx ? laneUpTx : locked[i]);
	end

	// R11: channel ready after full init
	// R13: transmit gated by channel ready
	always_ff @(posedge clk)
	begin
		channelUp <= !sys_rst && next_initState == ST_READY && initState == ST_READY;
		txReady   <= !sys_rst && next_initState == ST_READY && initState == ST_READY &&
			!(simplexMode && !simplexTx);
	end

	// R14: receive gated by all lanes
	// R12: stream valid is the only qualifier
	always_ff @(posedge clk)
	begin
		rxStreamValid <= !sys_rst && rxValidIn && allLocked && initState != ST_RESET &&
			initState != ST_WAIT_REMOTE && !(simplexMode && simplexTx);
	end

	// R16: periodic bonding block request
	always_ff @(posedge clk)
	begin
		sendBond <= !sys_rst && simplexMode && simplexTx && initState != ST_RESET &&
			bondTimerDone;
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB register slave with one wait state.

	assign apbAccess = apbReq.psel && apbReq.penable && apbRsp.pready;
	assign apbWrite  = apbAccess && apbReq.pwrite;

	// Read data and error for the addressed word.
	always_comb
	begin
		next_prdata  = '0;
		next_pslverr = 1'b0;
		case (apbReq.paddr)
			REG_CTRL:
			begin
				next_prdata[CTRL_SIMPLEX_BIT] = simplexMode;
				next_prdata[CTRL_TXSIDE_BIT]  = simplexTx;
			end
			REG_STATUS:
			begin
				next_prdata[NUM_LANES-1:0] = laneUp;
				next_prdata[STAT_CHAN_BIT]  = channelUp;
				next_prdata[STAT_WAIT_BIT]  = (initState == ST_WAIT_REMOTE);
				next_prdata[STAT_STATE_POS +: 3] = initState;
			end
			REG_SOFTCNT:
				next_prdata = softCount;
			REG_TIMER:
				next_prdata[TIMER_W-1:0] = timerValue;
			default:
				next_pslverr = 1'b1;
		endcase
	end

	// Answer one cycle into the access phase.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			apbRsp <= '0;
		else
		begin
			apbRsp.pready  <= apbReq.psel && apbReq.penable && !apbRsp.pready;
			apbRsp.pslverr <= next_pslverr;
			apbRsp.prdata  <= next_prdata;
		end
	end

	// Control and timer registers.
	always_ff @(posedge clk)
	begin
		restartReq <= 1'b0;
		if (sys_rst)
		begin
			{simplexTx, simplexMode} <= CTRL_RESET;
			timerValue               <= TIMER_DEFAULT;
		end
		else if (apbWrite && apbReq.paddr == REG_CTRL)
		begin
			simplexMode <= apbReq.pwdata[CTRL_SIMPLEX_BIT];
			simplexTx   <= apbReq.pwdata[CTRL_TXSIDE_BIT];
			restartReq  <= apbReq.pwdata[CTRL_RESTART_BIT];
		end
		else if (apbWrite && apbReq.paddr == REG_TIMER)
			timerValue <= apbReq.pwdata[TIMER_W-1:0];
	end

	// Soft error counter; a new error wins over a clearing write.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			softCount <= '0;
		else if (apbWrite && apbReq.paddr == REG_SOFTCNT)
			softCount <= {31'h0, softDet};
		else if (softDet && softCount != 32'hFFFFFFFF)
			softCount <= softCount + 32'h1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.

	a_soft_bad_hdr: assert property (@(posedge clk) disable iff (sys_rst) // R7
		|badHdr |=> softErr)
		else $error("bad sync header gave no soft error");

	a_soft_bad_kind: assert property (@(posedge clk) disable iff (sys_rst) // R8
		|badKind && !fatalDet |=> softErr && !hardErr)
		else $error("unknown block kind mishandled");

	a_tx_fault_out: assert property (@(posedge clk) disable iff (sys_rst) // R5
		txFault && initState != ST_RESET |=> txHardErr && hardErr)
		else $error("transmit buffer fault not reported");

	a_rx_fault_out: assert property (@(posedge clk) disable iff (sys_rst) // R6
		rxFault && initState != ST_RESET |=> rxHardErr && hardErr)
		else $error("receive buffer fault not reported");

	a_fatal_restart: assert property (@(posedge clk) disable iff (sys_rst) // R4
		fatalDet |=> initState == ST_RESET && !channelUp ##1 !channelUp)
		else $error("fatal error did not restart initialization");

	a_slip_not_fatal: assert property (@(posedge clk) disable iff (sys_rst) // R3
		realign && !fatalDet |=> !hardErr)
		else $error("realignment reported as fatal");

	a_tx_after_up: assert property (@(posedge clk) disable iff (sys_rst) // R13
		txReady |-> channelUp)
		else $error("transmit allowed before channel ready");

	a_rx_lanes_up: assert property (@(posedge clk) disable iff (sys_rst) // R14
		rxStreamValid |-> $past(allLocked))
		else $error("data delivered before all lanes ready");

	a_chan_full_init: assert property (@(posedge clk) disable iff (sys_rst) // R11
		$rose(channelUp) |-> $past(initState, 2) != ST_RESET && $past(initState) == ST_READY)
		else $error("channel ready before initialization ended");

	a_wait_remote: assert property (@(posedge clk) disable iff (sys_rst) // R18
		initState == ST_READY && simplexMode && !simplexTx && !allLocked && !fatalDet &&
		!restartReq |=> initState == ST_WAIT_REMOTE ##1 !channelUp)
		else $error("broken simplex link did not wait for remote");

	a_reset_clears: assert property (@(posedge clk) // R23
		$past(sys_rst) |-> !softErr && !hardErr && !channelUp && laneUp == '0 && !txReady)
		else $error("outputs not cleared by reset");

endmodule // lsm_link_monitor

// ---- rtl/lsm_pkg.sv ----
// Shared constants, carriers and state type of the link status and init monitor.
package lsm_pkg;

	// Lane count and sync header codes.
	localparam int          NUM_LANES = 4;
	localparam logic [1:0]  HDR_DATA  = 2'h1;
	localparam logic [1:0]  HDR_CTRL  = 2'h2;

	// Block kind field codes known to the receiver.
	localparam logic [7:0]  KIND_IDLE    = 8'h78;
	localparam logic [7:0]  KIND_BOND    = 8'h7C;
	localparam logic [7:0]  KIND_CLKCOMP = 8'h80;
	localparam logic [7:0]  KIND_NFC     = 8'hAA;
	localparam logic [7:0]  KIND_UFC     = 8'h2D;
	localparam logic [7:0]  KIND_SEP     = 8'h1E;
	localparam logic [7:0]  KIND_SEP7    = 8'hE1;
	localparam logic [7:0]  USER_K_KIND [9] = '{8'hD2, 8'h99, 8'h55, 8'hB4, 8'hCC,
		8'h66, 8'h33, 8'h4B, 8'h87};

	// Block alignment thresholds.
	localparam logic [6:0]  LOCK_GOOD_COUNT = 7'h40;
	localparam logic [9:0]  WINDOW_LAST     = 10'h3FF;
	localparam logic [4:0]  BAD_LIMIT       = 5'h10;

	// Timers.
	localparam int          TIMER_W       = 24;
	localparam logic [23:0] TIMER_DEFAULT = 24'h000FFF;
	localparam logic [4:0]  RESET_HOLD    = 5'h10;

	// Register map and fields.
	localparam int          ADDR_W           = 12;
	localparam logic [11:0] REG_CTRL         = 12'h000;
	localparam logic [11:0] REG_STATUS       = 12'h004;
	localparam logic [11:0] REG_SOFTCNT      = 12'h008;
	localparam logic [11:0] REG_TIMER        = 12'h00C;
	localparam int          CTRL_SIMPLEX_BIT = 0;
	localparam int          CTRL_TXSIDE_BIT  = 1;
	localparam int          CTRL_RESTART_BIT = 2;
	localparam logic [1:0]  CTRL_RESET       = 2'h0;
	localparam int          STAT_CHAN_BIT    = 4;
	localparam int          STAT_WAIT_BIT    = 5;
	localparam int          STAT_STATE_POS   = 8;

	// One lane's view of the transceiver.
	typedef struct packed {
		logic       hdrValid;
		logic [1:0] header;
		logic [7:0] kind;
		logic       txBufErr;
		logic       rxBufErr;
		logic       pllLock;
	} lsm_lane_in_type;

	// APB request and answer.
	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} lsm_apb_req_type;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} lsm_apb_rsp_type;

	typedef enum logic [2:0] {ST_RESET, ST_LANE, ST_BOND, ST_READY, ST_WAIT_REMOTE}
		lsm_init_state_type;

	// True for any control block kind the receiver understands.
	function automatic logic kind_known(input logic [7:0] kind);
		logic hit;
		hit = (kind == KIND_IDLE) || (kind == KIND_BOND) || (kind == KIND_CLKCOMP) ||
			(kind == KIND_NFC) || (kind == KIND_UFC) || (kind == KIND_SEP) ||
			(kind == KIND_SEP7);
		for (int k = 0; k < 9; k++)
			hit = hit || (kind == USER_K_KIND[k]);
		return hit;
	endfunction

endpackage

// ---- rtl/lsm_timer.sv ----
// One-shot 24-bit down counter with a held done flag.
`timescale 1ns/100ps
module lsm_timer
(
	// Clock and reset.
	input  wire logic                        clk,
	input  wire logic                        sys_rst,
	// Control.
	input  wire logic                        load,
	input  wire logic [lsm_pkg::TIMER_W-1:0] loadValue,
	// Status.
	output logic                             done
);
	import lsm_pkg::*;

	logic [TIMER_W-1:0] count;
	logic               armed;

	// Counts down after a load and raises done when zero is reached.
	always_ff @(posedge clk)
	begin
		if (sys_rst || load)
		begin
			count <= sys_rst ? '0 : loadValue;
			armed <= !sys_rst;
			done  <= 1'b0;
		end
		else if (armed)
		begin
			if (count == '0)
			begin
				armed <= 1'b0;
				done  <= 1'b1;
			end
			else
				count <= count - 1'b1;
		end
	end

endmodule // lsm_timer

// ---- rtl/lsm_lane_align.sv ----
// Per-lane block alignment machine working on received sync headers.
`timescale 1ns/100ps
module lsm_lane_align
(
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       restart,
	// Header stream.
	input  wire logic       hdrValid,
	input  wire logic [1:0] header,
	// Alignment state.
	output logic            locked,
	output logic            slip
);
	import lsm_pkg::*;

	logic       hdrGood;
	logic [6:0] goodCnt;
	logic [9:0] winCnt;
	logic [4:0] badCnt;

	assign hdrGood = (header == HDR_DATA) || (header == HDR_CTRL);

	// R3: realign on bad bursts
	always_ff @(posedge clk)
	begin
		slip <= 1'b0;
		if (sys_rst || restart)
		begin
			locked  <= 1'b0;
			goodCnt <= '0;
			winCnt  <= '0;
			badCnt  <= '0;
		end
		else if (hdrValid && !locked)
		begin
			goodCnt <= hdrGood ? goodCnt + 1'b1 : '0;
			slip    <= !hdrGood;
			locked  <= hdrGood && (goodCnt == LOCK_GOOD_COUNT - 7'h1);
		end
		else if (hdrValid)
		begin
			winCnt <= (winCnt == WINDOW_LAST) ? '0 : winCnt + 1'b1;
			if (!hdrGood && (badCnt == BAD_LIMIT - 5'h1))
			begin
				locked  <= 1'b0;
				slip    <= 1'b1;
				goodCnt <= '0;
				winCnt  <= '0;
				badCnt  <= '0;
			end
			else if (winCnt == WINDOW_LAST)
				badCnt <= '0;
			else if (!hdrGood)
				badCnt <= badCnt + 1'b1;
		end
	end

	// R3: lock lost on burst
	a_burst_unlock: assert property (@(posedge clk) disable iff (sys_rst || restart) // R3
		locked && hdrValid && !hdrGood && badCnt == BAD_LIMIT - 5'h1 |=> !locked && slip)
		else $error("alignment kept lock after a bad header burst");

endmodule // lsm_lane_align

// ---- tb/lsm_lane_model.sv ----
// Far-end lane model: sync headers, block kinds and transceiver status.
`timescale 1ns/100ps
module lsm_lane_model
(
	// Clock.
	input  wire logic                                         clk,
	// Header mode (0 data, 1 bond, 2 bad header, 3 bad kind) and faults.
	input  wire logic [1:0]                                   mode,
	input  wire logic [2:0]                                   fault,
	// Lanes towards the device.
	output lsm_pkg::lsm_lane_in_type [lsm_pkg::NUM_LANES-1:0] laneOut
);
	import lsm_pkg::*;

	lsm_lane_in_type one;

	////////////////////////////////////////////////////////////////////////////
	// Builds the block that every lane carries next cycle.
	always_comb
	begin
		one = '{hdrValid: 1'b1, header: HDR_DATA, kind: KIND_IDLE,
			txBufErr: fault[0], rxBufErr: fault[1], pllLock: !fault[2]};
		case (mode)
			2'h1: {one.header, one.kind} = {HDR_CTRL, KIND_BOND};
			2'h2: one.header = 2'h3;
			2'h3: {one.header, one.kind} = {HDR_CTRL, 8'h01};
			default: ;
		endcase
	end

	// Lanes change one clock after the controls, like a registered link.
	initial laneOut = '0;
	always @(posedge clk)
		laneOut <= {NUM_LANES{one}};
endmodule // lsm_lane_model

// ---- tb/tb.sv ----
// Self-checking bench for the link status and init monitor.
`timescale 1ns/100ps
module tb;
	import lsm_pkg::*;

	logic                            clk;
	logic                            sys_rst;
	lsm_apb_req_type                 apbReq;
	lsm_apb_rsp_type                 apbRsp;
	lsm_lane_in_type [NUM_LANES-1:0] laneIn;
	logic                            rxValidIn, rxStreamValid, softErr;
	logic                            hardErr, txHardErr, rxHardErr;
	logic [NUM_LANES-1:0]            laneUp;
	logic                            channelUp, txReady, sendBond;
	logic [1:0]                      mode;
	logic [2:0]                      fault;
	logic [31:0]                     rdata;
	logic                            err;
	int                              n_errors, cmp_count, k;
	int                              cycles = 0;

	////////////////////////////////////////////////////////////////////////////
	// Clock at 200 MHz.
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	lsm_link_monitor #(.BOND_PERIOD(24'h000020)) i_dut (.clk(clk), .sys_rst(sys_rst),
		.apbReq(apbReq), .apbRsp(apbRsp), .laneIn(laneIn), .rxValidIn(rxValidIn),
		.rxStreamValid(rxStreamValid), .softErr(softErr), .hardErr(hardErr),
		.txHardErr(txHardErr), .rxHardErr(rxHardErr), .laneUp(laneUp),
		.channelUp(channelUp), .txReady(txReady), .sendBond(sendBond));

	lsm_lane_model i_far (.clk(clk), .mode(mode), .fault(fault), .laneOut(laneIn));

	// Cuts a hang short.
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			n_errors++;
			tally_and_finish();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
			n_errors++;
		end
	endtask

	// One APB transfer; only the bench timeout ends the wait for pready.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk);
		apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
		@(posedge clk);
		apbReq.penable <= 1'b1;
		do
			@(posedge clk);
		while (apbRsp.pready !== 1'b1);
		rdata = apbRsp.prdata;
		err = apbRsp.pslverr;
		apbReq <= '0;
	endtask

	task automatic t_reset();
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (10) @(posedge clk);
		chk("laneUp in reset", 32'h0, laneUp);
		chk("channelUp in reset", 32'h0, channelUp);
		sys_rst <= 1'b0;
	endtask

	task automatic t_init();
		mode <= 2'h0;
		repeat (20) @(posedge clk);
		for (k = 0; k < 300 && laneUp !== 4'hF; k++) @(posedge clk);
		chk("laneUp", 32'hF, laneUp);
		chk("channelUp before bond", 32'h0, channelUp);
		chk("txReady before bond", 32'h0, txReady);
		repeat (2) @(posedge clk);
		chk("rxStreamValid early", 32'h1, rxStreamValid);
		rxValidIn <= 1'b0;
		@(posedge clk);
		rxValidIn <= 1'b1;
		@(posedge clk);
		chk("rxStreamValid follows valid", 32'h0, rxStreamValid);
		mode <= 2'h1;
		for (k = 0; k < 50 && channelUp !== 1'b1; k++) @(posedge clk);
		mode <= 2'h0;
		chk("channelUp", 32'h1, channelUp);
		chk("txReady", 32'h1, txReady);
	endtask

	// One offending block; expects a single soft error pulse or none.
	task automatic t_soft(input logic [1:0] m, input logic [31:0] exp);
		int n;
		@(posedge clk);
		mode <= m;
		@(posedge clk);
		mode <= 2'h0;
		n = 0;
		repeat (5) @(posedge clk) n += int'(softErr === 1'b1);
		chk("softErr pulses", exp, n);
	endtask

	task automatic t_fatal(input logic [2:0] f, input logic [2:0] exp);
		logic [2:0] seen;
		fault <= f;
		@(posedge clk);
		fault <= 3'h0;
		seen = '0;
		repeat (5) @(posedge clk) seen |= {hardErr, txHardErr, rxHardErr};
		chk("hard error flags", exp, seen);
		chk("channelUp after fatal", 32'h0, channelUp);
		t_init();
	endtask

	task automatic t_burst();
		int n;
		logic h;
		@(posedge clk);
		mode <= 2'h2;
		n = 0;
		h = 1'b0;
		repeat (24) @(posedge clk)
		begin
			n += int'(softErr === 1'b1);
			h |= hardErr;
			if (k == 0)
				mode <= 2'h2;
		end
		chk("burst hardErr", 32'h0, h);
		chk("burst laneUp", 32'h0, laneUp);
		chk("burst softErr cycles", 32'd22, n);
		t_init();
	endtask

	// Simplex receive side: break, wait for remote, recover on a bond block.
	task automatic t_simplex_rx();
		apb(1'b1, REG_CTRL, 32'h5);
		repeat (20) @(posedge clk);
		for (k = 0; k < 300 && laneUp !== 4'hF; k++) @(posedge clk);
		mode <= 2'h1;
		for (k = 0; k < 50 && channelUp !== 1'b1; k++) @(posedge clk);
		chk("rx channelUp", 32'h1, channelUp);
		chk("rx txReady", 32'h0, txReady);
		mode <= 2'h2;
		repeat (24) @(posedge clk);
		chk("rx channelUp broken", 32'h0, channelUp);
		mode <= 2'h0;
		for (k = 0; k < 300 && laneUp !== 4'hF; k++) @(posedge clk);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("rx wait remote", 32'h2F, rdata[5:0]);
		mode <= 2'h1;
		for (k = 0; k < 50 && channelUp !== 1'b1; k++) @(posedge clk);
		mode <= 2'h0;
		chk("rx recovered", 32'h1, channelUp);
	endtask

	task automatic t_simplex_tx();
		int n;
		apb(1'b0, REG_TIMER, 32'h0);
		chk("timer reset value", 32'h000FFF, rdata);
		apb(1'b1, REG_TIMER, 32'h8);
		apb(1'b1, REG_CTRL, 32'h7);
		apb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl readback", 32'h3, rdata);
		chk("laneUp after restart", 32'h0, laneUp);
		for (k = 0; k < 80 && laneUp !== 4'hF; k++) @(posedge clk);
		chk("tx laneUp by timer", 32'hF, laneUp);
		for (k = 0; k < 80 && channelUp !== 1'b1; k++) @(posedge clk);
		chk("tx channelUp by timer", 32'h1, channelUp);
		n = 0;
		repeat (68) @(posedge clk) n += int'(sendBond === 1'b1);
		chk("bond blocks sent", 32'd2, n);
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped error", 32'h1, err);
		chk("unmapped data", 32'h0, rdata);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("status", 32'h31F, rdata[10:0]);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial
	begin
		sys_rst = 1'b1;
		apbReq = '0;
		rxValidIn = 1'b1;
		mode = 2'h2;
		fault = 3'h0;
		n_errors = 0;
		cmp_count = 0;
		t_reset();
		repeat (5) @(posedge clk);
		chk("rxStreamValid unlocked", 32'h0, rxStreamValid);
		t_init();
		t_soft(2'h2, 32'd1);
		t_soft(2'h3, 32'd1);
		t_soft(2'h1, 32'd0);
		t_fatal(3'h1, 3'h6);
		t_fatal(3'h2, 3'h5);
		t_fatal(3'h4, 3'h4);
		t_burst();
		t_simplex_rx();
		t_simplex_tx();
		t_reset();
		tally_and_finish();
	end
endmodule // tb
